// ### asmd_cfg.svh
`ifndef ASMD_CFG_SVH
`define ASMD_CFG_SVH
/*
  offsets, field positions, reset values and timing figures of the speed-mode detector.
  assumes inclusion by bare name from the design file only.
*/
// register offsets
`define ASMD_SPEED_CTRL_ADDR  8'h02
`define ASMD_STATUS_ADDR      8'h03
// speed_mode_control fields
`define ASMD_FM_LO_BIT        0
`define ASMD_FM_HI_BIT        1
`define ASMD_FMT_LSB          4
`define ASMD_FMT_MSB          6
`define ASMD_SPEED_CTRL_RST   8'h00
// format counts
`define ASMD_FMT_COUNT_SA     3'h4
`define ASMD_FMT_COUNT_CP     3'h6
// clock and frame-rate windows, in hertz
`define ASMD_CLK_HZ           10000000
`define ASMD_SS_MIN_HZ        4000
`define ASMD_SS_MAX_HZ        50000
`define ASMD_DS_MIN_HZ        84000
`define ASMD_DS_MAX_HZ        100000
`define ASMD_QS_MIN_HZ        170000
`define ASMD_QS_MAX_HZ        200000
`endif

// ### asmd_pkg.sv
/*
  types of the speed-mode detector.
  assumes nothing beyond a SystemVerilog compiler.
*/
package asmd_pkg;
    typedef enum logic [2:0] {
        ASMD_SPD_NONE   = 3'b000,
        ASMD_SPD_SINGLE = 3'b001,
        ASMD_SPD_DOUBLE = 3'b010,
        ASMD_SPD_QUAD   = 3'b100
    } asmd_speed_type;
endpackage : asmd_pkg

// ### asmd_speed_detect.sv
/*
  speed-mode detection, forced-mode override and master/frame ratio check.
  assumes frame_clock, master_div_clock, standalone and format pins come from outside
  this clock domain; register port is driven by logic on clk.
*/
`timescale 1ns/100ps
`include "asmd_cfg.svh"

// Function
// - after reset automatic detection runs without any register write
// - auto picks single 4-50k, double 84-100k, quad 170-200k
// - only a non-zero speed-select value in register 02h overrides detection
// - select 00 auto, 01 single, 10 double, 11 quad; forced means no detection
// - stand-alone operation always uses automatic detection
// - four formats stand-alone, six formats with control port
// - mute output active whenever measured ratio is invalid
module asmd_speed_detect
    import asmd_pkg::*;
#(
    parameter int PRESCALE = 32,
    parameter int STABLE   = 4
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // pins
    input  wire logic        frame_clock,
    input  wire logic        master_div_clock,
    input  wire logic        standalone,
    input  wire logic [1:0]  format_pins,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_write,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // status
    output asmd_speed_type   speed_mode,
    output logic             unsupported,
    output logic             mute_control_out,
    output logic      [2:0]  active_format,
    output logic             format_invalid
);
    localparam int SS_MAX_CYC = `ASMD_CLK_HZ / `ASMD_SS_MIN_HZ;
    localparam int SS_MIN_CYC = (`ASMD_CLK_HZ + `ASMD_SS_MAX_HZ - 1) / `ASMD_SS_MAX_HZ;
    localparam int DS_MAX_CYC = `ASMD_CLK_HZ / `ASMD_DS_MIN_HZ;
    localparam int DS_MIN_CYC = (`ASMD_CLK_HZ + `ASMD_DS_MAX_HZ - 1) / `ASMD_DS_MAX_HZ;
    localparam int QS_MAX_CYC = `ASMD_CLK_HZ / `ASMD_QS_MIN_HZ;
    localparam int QS_MIN_CYC = (`ASMD_CLK_HZ + `ASMD_QS_MAX_HZ - 1) / `ASMD_QS_MAX_HZ;
    localparam int PER_W      = $clog2(SS_MAX_CYC + 2);
    localparam logic [PER_W-1:0] PER_SAT = '1;
    localparam logic [2:0]       AGREE_LAST = 3'(STABLE - 1);

    // pin synchronisers: three flops, a change counts once the last two agree
    logic [4:0] pin_raw;
    logic [4:0] pin_f;
    assign pin_raw = {format_pins, standalone, master_div_clock, frame_clock};
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            logic s1, s2, s3, filt, next_filt;
            always_comb begin
                next_filt = (s2 == s3) ? s3 : filt;
            end
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    s1   <= 1'b0;
                    s2   <= 1'b0;
                    s3   <= 1'b0;
                    filt <= 1'b0;
                end else begin
                    s1   <= pin_raw[gi];
                    s2   <= s1;
                    s3   <= s2;
                    filt <= next_filt;
                end
            end
            assign pin_f[gi] = filt;
        end
    endgenerate

    function automatic asmd_speed_type classify(input logic [PER_W-1:0] per);
        int p;
        p = int'(per);
        if (p >= SS_MIN_CYC && p <= SS_MAX_CYC)      classify = ASMD_SPD_SINGLE;
        else if (p >= DS_MIN_CYC && p <= DS_MAX_CYC) classify = ASMD_SPD_DOUBLE;
        else if (p >= QS_MIN_CYC && p <= QS_MAX_CYC) classify = ASMD_SPD_QUAD;
        else                                         classify = ASMD_SPD_NONE;
    endfunction : classify

    function automatic logic ratio_valid(input asmd_speed_type m, input logic [5:0] cnt);
        int r;
        r = int'(cnt) * PRESCALE;
        ratio_valid = 1'b0;
        unique case (m)
            ASMD_SPD_SINGLE: ratio_valid = r inside {256, 384, 512, 768, 1024, 1152};
            ASMD_SPD_DOUBLE: ratio_valid = r inside {128, 192, 256, 384, 512};
            ASMD_SPD_QUAD:   ratio_valid = r inside {64, 96, 128, 192, 256};
            default:         ratio_valid = 1'b0;
        endcase
    endfunction : ratio_valid

    logic           frame_d, mdiv_d, started, ratio_ok, unsup;
    logic [PER_W-1:0] period;
    logic [5:0]     mcnt;
    logic [2:0]     agree;
    logic [7:0]     speed_ctrl;
    asmd_speed_type last_cand, detected;
    logic           next_frame_d, next_mdiv_d, next_started, next_ratio_ok, next_unsup;
    logic [PER_W-1:0] next_period;
    logic [5:0]     next_mcnt, mcnt_now;
    logic [2:0]     next_agree;
    logic [7:0]     next_speed_ctrl;
    asmd_speed_type next_last_cand, next_detected, cand, active;
    logic           frame_rise, mdiv_rise, forced;
    logic [1:0]     fm;

    assign frame_rise = pin_f[0] & ~frame_d;
    assign mdiv_rise  = pin_f[1] & ~mdiv_d;
    assign fm = {speed_ctrl[`ASMD_FM_HI_BIT], speed_ctrl[`ASMD_FM_LO_BIT]};
    // stand-alone has no override path, only the register can force a mode
    assign forced = !pin_f[2] && (fm != 2'b00);

    always_comb begin
        unique case (fm)
            2'b01:   active = ASMD_SPD_SINGLE;
            2'b10:   active = ASMD_SPD_DOUBLE;
            2'b11:   active = ASMD_SPD_QUAD;
            default: active = detected;
        endcase
        if (!forced) begin
            active = detected;
        end
    end

    always_comb begin
        next_frame_d    = pin_f[0];
        next_mdiv_d     = pin_f[1];
        next_started    = started;
        next_ratio_ok   = ratio_ok;
        next_unsup      = unsup;
        next_agree      = agree;
        next_last_cand  = last_cand;
        next_detected   = detected;
        next_speed_ctrl = speed_ctrl;
        cand            = classify(period);
        mcnt_now = (mdiv_rise && mcnt != 6'h3f) ? mcnt + 6'h01 : mcnt;
        next_mcnt   = mcnt_now;
        next_period = (period != PER_SAT) ? period + 1'b1 : period;
        if (reg_write && reg_addr == `ASMD_SPEED_CTRL_ADDR) begin
            next_speed_ctrl = reg_wdata;
        end
        if (frame_rise) begin
            next_started = 1'b1;
            next_period  = '0 + 1'b1;
            next_mcnt    = '0;
            next_ratio_ok = started && ratio_valid(active, mcnt_now);
            if (started) begin
                next_last_cand = cand;
                // a new mode must repeat for STABLE periods before it is taken
                if (cand == last_cand && cand != ASMD_SPD_NONE) begin
                    if (agree != AGREE_LAST) next_agree = agree + 3'h1;
                end else begin
                    next_agree = '0;
                end
                next_unsup = (cand == ASMD_SPD_NONE);
                if (!forced && cand == last_cand && cand != ASMD_SPD_NONE
                    && agree >= AGREE_LAST - 3'h1) begin
                    next_detected = cand;
                end
            end
        end else if (period == PER_SAT) begin
            // frame clock stopped: nothing valid to measure, mute and flag
            next_unsup    = 1'b1;
            next_ratio_ok = 1'b0;
            next_agree    = '0;
            next_started  = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            frame_d    <= 1'b0;
            mdiv_d     <= 1'b0;
            started    <= 1'b0;
            ratio_ok   <= 1'b0;
            unsup      <= 1'b0;
            period     <= '0;
            mcnt       <= '0;
            agree      <= '0;
            last_cand  <= ASMD_SPD_NONE;
            detected   <= ASMD_SPD_SINGLE;
            speed_ctrl <= `ASMD_SPEED_CTRL_RST;
        end else begin
            frame_d    <= next_frame_d;
            mdiv_d     <= next_mdiv_d;
            started    <= next_started;
            ratio_ok   <= next_ratio_ok;
            unsup      <= next_unsup;
            period     <= next_period;
            mcnt       <= next_mcnt;
            agree      <= next_agree;
            last_cand  <= next_last_cand;
            detected   <= next_detected;
            speed_ctrl <= next_speed_ctrl;
        end
    end

    // outputs, registered
    logic [7:0]     next_rdata;
    logic [2:0]     next_fmt;
    logic           next_fmt_bad;
    always_comb begin
        next_rdata = 8'h00;
        if (reg_addr == `ASMD_SPEED_CTRL_ADDR) begin
            next_rdata = speed_ctrl;
        end else if (reg_addr == `ASMD_STATUS_ADDR) begin
            next_rdata = {4'h0, ~ratio_ok, unsup, active[2] | active[1], active[2] | active[0]};
        end
        if (pin_f[2]) begin
            next_fmt     = {1'b0, pin_f[4:3]};
            next_fmt_bad = 1'b0;
        end else begin
            next_fmt     = speed_ctrl[`ASMD_FMT_MSB:`ASMD_FMT_LSB];
            next_fmt_bad = next_fmt >= `ASMD_FMT_COUNT_CP;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata        <= 8'h00;
            speed_mode       <= ASMD_SPD_SINGLE;
            unsupported      <= 1'b0;
            mute_control_out <= 1'b1;
            active_format    <= 3'h0;
            format_invalid   <= 1'b0;
        end else begin
            reg_rdata        <= next_rdata;
            speed_mode       <= active;
            unsupported      <= unsup;
            mute_control_out <= ~ratio_ok;
            active_format    <= next_fmt;
            format_invalid   <= next_fmt_bad;
        end
    end
endmodule : asmd_speed_detect

// ### asmd_notes_unused.sv
`timescale 1ns/100ps

// ### asmd_speed_detect_asserts.sv
/*
  concurrent checks on the ports of the speed-mode detector.
  assumes bind to asmd_speed_detect; one clock domain, rstn synchronous low.
*/
`timescale 1ns/100ps
module asmd_speed_detect_asserts
    import asmd_pkg::*;
(
    // clock and reset
    input wire logic           clk,
    input wire logic           rstn,
    // pins
    input wire logic           frame_clock,
    input wire logic           master_div_clock,
    input wire logic           standalone,
    input wire logic [1:0]     format_pins,
    // register port
    input wire logic [7:0]     reg_addr,
    input wire logic           reg_write,
    input wire logic [7:0]     reg_wdata,
    input wire logic [7:0]     reg_rdata,
    // status
    input wire asmd_speed_type speed_mode,
    input wire logic           unsupported,
    input wire logic           mute_control_out,
    input wire logic [2:0]     active_format,
    input wire logic           format_invalid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // cycles since the last frame edge, saturating; in stand-alone, mode may only move near an edge
    logic       fc_q;
    logic [3:0] still;
    logic [3:0] next_still;
    always_comb begin
        next_still = (frame_clock != fc_q) ? 4'h0 : still + {3'h0, still != 4'hf};
    end
    always_ff @(posedge clk) begin
        fc_q  <= frame_clock;
        still <= rstn ? next_still : 4'h0;
    end
    AST_RESET_STATE: assert property (disable iff (1'b0)
        !rstn |=> mute_control_out && speed_mode == ASMD_SPD_SINGLE) else $error("bad reset state");
    AST_WRITE_READBACK: assert property (
        (reg_write && reg_addr == 8'h02) ##1 (reg_addr == 8'h02 && !reg_write)
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback differs");
    AST_UNMAPPED_ZERO: assert property (
        reg_addr != 8'h02 && reg_addr != 8'h03 |=> reg_rdata == 8'h00) else $error("unmapped read");
    AST_FORCED_MODE: assert property (
        !standalone && !$past(standalone, 8) && reg_addr == 8'h02 && $past(reg_addr, 2) == 8'h02
        && $stable(reg_addr) && $stable(reg_rdata) && reg_rdata[1:0] != 2'h0 |-> speed_mode ==
        {&reg_rdata[1:0], reg_rdata[1] & ~reg_rdata[0], ~reg_rdata[1] & reg_rdata[0]})
        else $error("forced mode not applied");
    AST_ONE_MODE: assert property ($onehot(speed_mode)) else $error("mode not one-hot");
    AST_HOLD_UNSUP: assert property (
        standalone && unsupported && $past(unsupported) |-> $stable(speed_mode))
        else $error("mode moved while unsupported");
    AST_QUIET_HOLD: assert property (
        standalone && $past(standalone, 8) && still == 4'hf |-> $stable(speed_mode))
        else $error("mode moved without frame edge");
    AST_SA_FORMAT: assert property (
        standalone && $past(standalone, 8) |-> active_format < 3'h4 && !format_invalid)
        else $error("stand-alone format out of range");
    AST_CP_FORMAT: assert property (
        !standalone && reg_addr == 8'h02 && $past(reg_addr, 2) == 8'h02 && $stable(reg_addr)
        && $stable(reg_rdata)
        |-> format_invalid == (reg_rdata[6:4] >= 3'h6)) else $error("format check wrong");
    cover property (speed_mode == ASMD_SPD_QUAD);
    cover property (unsupported && !mute_control_out);
    cover property (format_invalid);
endmodule : asmd_speed_detect_asserts

bind asmd_speed_detect asmd_speed_detect_asserts i_chk (
    .clk              (clk),
    .rstn             (rstn),
    .frame_clock      (frame_clock),
    .master_div_clock (master_div_clock),
    .standalone       (standalone),
    .format_pins      (format_pins),
    .reg_addr         (reg_addr),
    .reg_write        (reg_write),
    .reg_wdata        (reg_wdata),
    .reg_rdata        (reg_rdata),
    .speed_mode       (speed_mode),
    .unsupported      (unsupported),
    .mute_control_out (mute_control_out),
    .active_format    (active_format),
    .format_invalid   (format_invalid)
);

// ### asmd_clk_src.sv
/*
  model of the external clock source: frame clock and divided master clock.
  assumes clk is the bench clock; both clocks stand low while run is low.
*/
`timescale 1ns/100ps
module asmd_clk_src (
    // clock and settings
    input  wire logic clk,
    input  wire logic run,
    input  wire integer per,
    input  wire integer rises,
    // clocks to the block
    output logic      frame_clock = 1'b0,
    output logic      master_div_clock = 1'b0
);
    int cnt = 0;
    // both derived from one counter so frames stay locked to the master clock
    // pins move on the falling edge, like every other bench-driven input
    always @(negedge clk) begin
        cnt <= (!run || cnt >= per - 1) ? 0 : cnt + 1;
        frame_clock <= run && (cnt < per / 2);
        master_div_clock <= run && ((cnt * rises * 2 / per) % 2 == 1);
    end
endmodule : asmd_clk_src

// ### tb_top.sv
/*
  self-checking bench for the speed-mode detector.
  assumes the clock source model and the checker bind are compiled alongside.
*/
`timescale 1ns/100ps
module tb_top;
    logic                     clk = 1'b0;
    logic                     rstn = 1'b0;
    logic                     standalone = 1'b0;
    logic [1:0]               format_pins = 2'h2;
    logic [7:0]               reg_addr = 8'h00;
    logic                     reg_write = 1'b0;
    logic [7:0]               reg_wdata = 8'h00;
    logic [7:0]               reg_rdata;
    asmd_pkg::asmd_speed_type speed_mode;
    logic                     unsupported, mute_control_out, format_invalid;
    logic                     frame_clock, master_div_clock, run = 1'b0;
    logic [2:0]               active_format;
    int                       per = 104;
    int                       rises = 4;
    int                       n_fail = 0;
    int                       check_count = 0;
    asmd_speed_detect i_dut (
        .clk              (clk),
        .rstn             (rstn),
        .frame_clock      (frame_clock),
        .master_div_clock (master_div_clock),
        .standalone       (standalone),
        .format_pins      (format_pins),
        .reg_addr         (reg_addr),
        .reg_write        (reg_write),
        .reg_wdata        (reg_wdata),
        .reg_rdata        (reg_rdata),
        .speed_mode       (speed_mode),
        .unsupported      (unsupported),
        .mute_control_out (mute_control_out),
        .active_format    (active_format),
        .format_invalid   (format_invalid)
    );
    asmd_clk_src i_src (
        .clk              (clk),
        .run              (run),
        .per              (per),
        .rises            (rises),
        .frame_clock      (frame_clock),
        .master_div_clock (master_div_clock)
    );
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic conclude;
        if (n_fail == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        repeat (2) @(negedge clk);
        chk(reg_rdata, exp);
    endtask : rd
    // measurement needs a start rise plus four agreeing periods, so allow eight
    task automatic clocks(input int p, input int k);
        per   = p;
        rises = k;
        run   = 1'b1;
        repeat (8 * p) @(negedge clk);
    endtask : clocks
    task automatic mode(input logic [2:0] exp, input logic m);
        chk({5'h0, speed_mode}, {5'h0, exp});
        chk({7'h0, mute_control_out}, {7'h0, m});
    endtask : mode
    task automatic t_auto;
        clocks(50, 2);
        mode(3'h4, 1'b0);
        rd(8'h03, 8'h03);
        clocks(100, 4);
        mode(3'h2, 1'b0);
        clocks(2500, 8);
        mode(3'h1, 1'b0);
    endtask : t_auto
    task automatic t_gap;
        clocks(104, 4);
        clocks(150, 4);
        chk({7'h0, unsupported}, 8'h01);
        chk({5'h0, speed_mode}, 8'h02);
        rd(8'h03, 8'h06);
        clocks(104, 3);
        mode(3'h2, 1'b1);
        rd(8'h03, 8'h0a);
    endtask : t_gap
    task automatic t_forced;
        clocks(104, 4);
        for (int i = 1; i < 4; i++) begin
            wr(8'h02, 8'h50 | 8'(i));
            rd(8'h02, 8'h50 | 8'(i));
            chk({5'h0, speed_mode}, 8'h01 << (i - 1));
        end
        chk({4'h0, format_invalid, active_format}, 8'h05);
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h00);
        wr(8'h02, 8'h60);
        rd(8'h02, 8'h60);
        chk({7'h0, format_invalid}, 8'h01);
        chk({5'h0, speed_mode}, 8'h02);
    endtask : t_forced
    task automatic t_standalone;
        wr(8'h02, 8'h01);
        standalone = 1'b1;
        clocks(104, 4);
        chk({5'h0, speed_mode}, 8'h02);
        chk({4'h0, format_invalid, active_format}, 8'h02);
        // a gap and a quad rate while stand-alone, with the forcing value still written
        clocks(150, 4);
        chk({7'h0, unsupported}, 8'h01);
        chk({5'h0, speed_mode}, 8'h02);
        clocks(50, 2);
        mode(3'h4, 1'b0);
    endtask : t_standalone
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        mode(3'h1, 1'b1);
        t_auto;
        t_gap;
        t_forced;
        t_standalone;
        conclude;
    end
    // whole run is about 30k cycles
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        conclude;
    end
endmodule : tb_top
